// ### sccs_pkg.sv
/*
 * Constants for the system clock source selector: source select codes,
 * divider field geometry and reset values.
 * Assumes every clock source arrives as a level sampled on MCLK.
 */
package sccs_pkg;

    // ------------------------------------------------------------------
    // Source select codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_WAKEUP = 2'h0;
    localparam logic [1:0] SEL_RSVD = 2'h1;
    localparam logic [1:0] SEL_PRESCALE = 2'h2;
    localparam logic [1:0] SEL_DIRECT = 2'h3;

    // Prescaler input select: crystal or on-chip internal source.
    localparam logic OSC_CRYSTAL = 1'b0;
    localparam logic OSC_INTERNAL = 1'b1;

    // ------------------------------------------------------------------
    // Divider field and reset values
    // ------------------------------------------------------------------
    localparam int DIV_W = 10;
    localparam int MODE_W = 4;
    localparam logic [DIV_W-1:0] DIV_RESET = 10'h000;
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
    // Mode word layout: {source select, bypass, prescaler input}.
    localparam int MODE_SEL_HI = 3;
    localparam int MODE_SEL_LO = 2;
    localparam int MODE_BYP = 1;
    localparam int MODE_OSC = 0;

    typedef enum {
        ST_RUN,
        ST_PARK,
        ST_ARM
    } sccs_state_t;

endpackage : sccs_pkg

// ### sccs_div_if.sv
/*
 * Carrier between the selector and its prescaler: source level in,
 * divider field in, divided level out.
 * Assumes both ends run on MCLK.
 */
`timescale 1ns/1ns
interface sccs_div_if;
    logic src;
    logic [sccs_pkg::DIV_W-1:0] field;
    logic div;

    modport ctrl (output src, output field, input div);
    modport pre (input src, input field, output div);
endinterface : sccs_div_if

// ### sccs_div.sv
/*
 * Prescaler: divides a sampled source level by field plus one.
 * Assumes the source toggles no faster than every MCLK cycle.
 */
`timescale 1ns/1ns
module sccs_div (
    input wire logic mclk, // System sampling clock.
    input wire logic reset_n, // Synchronous reset, active low.
    sccs_div_if.pre dif // Source, field and divided output.
);

    logic prev_q;
    logic out_q;
    logic [sccs_pkg::DIV_W-1:0] cnt_q;
    logic [sccs_pkg::DIV_W-1:0] fld_q;
    logic edge_seen;

    assign edge_seen = dif.src != prev_q;
    assign dif.div = out_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= dif.src;
        end
    end

    // Counting both edges and toggling every factor edges gives a period
    // of exactly factor source periods for odd and even factors alike.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt_q <= sccs_pkg::DIV_RESET;
            fld_q <= sccs_pkg::DIV_RESET;
            out_q <= 1'b0;
        end else if (fld_q == sccs_pkg::DIV_RESET) begin
            out_q <= dif.src;
            fld_q <= dif.field;
            cnt_q <= sccs_pkg::DIV_RESET;
        end else if (edge_seen) begin
            if (cnt_q == fld_q) begin
                cnt_q <= sccs_pkg::DIV_RESET;
                fld_q <= dif.field;
                if (dif.field == sccs_pkg::DIV_RESET) begin
                    // A move to factor one joins the source level here, so
                    // the phase in progress is ended or stretched, never cut.
                    out_q <= dif.src;
                end else begin
                    out_q <= ~out_q;
                end
            end else begin
                cnt_q <= cnt_q + 10'h001;
            end
        end
    end

endmodule : sccs_div

// ### sccs_top.sv
/*
 * System clock source selector: picks the wakeup clock, the loop
 * output, the prescaled crystal or internal source, or the external
 * clock pin, and switches between them without runt pulses.
 * Assumes all clock sources are levels synchronous to MCLK, each well
 * below half the MCLK rate, and that software sets the mode inputs.
 */
`timescale 1ns/1ns
module sccs_top (
    input wire logic MCLK, // Sampling clock, 125 MHz.
    input wire logic RESET_N, // Synchronous reset, active low.
    input wire logic [1:0] CLOCK_SOURCE_SELECT, // Source select field.
    input wire logic OSCILLATOR_BYPASS, // 1 prescaler, 0 loop.
    input wire logic PRESCALE_DIVIDER_FIELD_IN_SEL, // 1 internal source.
    input wire logic [9:0] PRESCALE_DIVIDER_FIELD, // Factor minus one.
    input wire logic EXT_CLOCK_PIN, // External clock pin level.
    input wire logic CRYSTAL_INPUT_PIN, // Crystal oscillator level.
    input wire logic INT_CLOCK, // Internal clock source level.
    input wire logic WAKEUP_CLOCK, // Wakeup clock source level.
    input wire logic LOOP_CLOCK, // Phase locked loop output level.
    output logic SYS_CLOCK, // System clock level.
    output logic SWITCH_BUSY, // High while a source change is parked or armed.
    output logic [3:0] ACTIVE_MODE // Mode word now in use.
);

    // ------------------------------------------------------------------
    // Mode word
    // ------------------------------------------------------------------
    logic [sccs_pkg::MODE_W-1:0] req_mode;
    logic [sccs_pkg::MODE_W-1:0] mode_q;
    logic [sccs_pkg::MODE_W-1:0] mode_d;
    sccs_pkg::sccs_state_t state_q;
    sccs_pkg::sccs_state_t state_d;
    logic sys_q;
    logic sys_d;
    logic busy_q;
    logic osc_level;
    logic cand;

    assign req_mode = {CLOCK_SOURCE_SELECT, OSCILLATOR_BYPASS,
                       PRESCALE_DIVIDER_FIELD_IN_SEL};

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    sccs_div_if dif ();

    always_comb begin
        if (mode_q[sccs_pkg::MODE_OSC] == sccs_pkg::OSC_INTERNAL) begin
            osc_level = INT_CLOCK;
        end else begin
            osc_level = CRYSTAL_INPUT_PIN;
        end
    end

    assign dif.src = osc_level;
    assign dif.field = PRESCALE_DIVIDER_FIELD;

    sccs_div u_div (
        .mclk(MCLK),
        .reset_n(RESET_N),
        .dif(dif.pre)
    );

    // ------------------------------------------------------------------
    // Source multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        case (mode_q[sccs_pkg::MODE_SEL_HI:sccs_pkg::MODE_SEL_LO])
            sccs_pkg::SEL_DIRECT: begin
                cand = EXT_CLOCK_PIN;
            end
            sccs_pkg::SEL_PRESCALE: begin
                if (mode_q[sccs_pkg::MODE_BYP]) begin
                    cand = dif.div;
                end else begin
                    cand = LOOP_CLOCK;
                end
            end
            sccs_pkg::SEL_WAKEUP: begin
                cand = WAKEUP_CLOCK;
            end
            sccs_pkg::SEL_RSVD: begin
                // The reserved code is treated as a safe low-rate fallback.
                cand = WAKEUP_CLOCK;
            end
            default: begin
                cand = WAKEUP_CLOCK;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Switch sequencer
    // ------------------------------------------------------------------
    // A change is only taken once the old clock sits low, and the new one
    // is only let through after it has been seen low, so neither a high
    // nor a low phase is ever cut short.
    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        sys_d = sys_q;
        case (state_q)
            sccs_pkg::ST_RUN: begin
                sys_d = cand;
                if (req_mode != mode_q) begin
                    state_d = sccs_pkg::ST_PARK;
                end
            end
            sccs_pkg::ST_PARK: begin
                if (sys_q == 1'b0) begin
                    sys_d = 1'b0;
                    mode_d = req_mode;
                    state_d = sccs_pkg::ST_ARM;
                end else begin
                    sys_d = cand;
                end
            end
            sccs_pkg::ST_ARM: begin
                sys_d = 1'b0;
                if (cand == 1'b0) begin
                    state_d = sccs_pkg::ST_RUN;
                end
            end
            default: begin
                sys_d = 1'b0;
                state_d = sccs_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            state_q <= sccs_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            mode_q <= sccs_pkg::MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            sys_q <= 1'b0;
        end else begin
            sys_q <= sys_d;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= state_d != sccs_pkg::ST_RUN;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign SYS_CLOCK = sys_q;
    assign SWITCH_BUSY = busy_q;
    assign ACTIVE_MODE = mode_q;

endmodule : sccs_top

// ### sccs_sva.sv
/* Checker for sccs_top, bound to its ports below.
   Assumes source levels change at most once per MCLK cycle. */
`timescale 1ns/1ns
module sccs_sva (
    input wire logic MCLK, // Clock.
    input wire logic RESET_N, // Reset.
    input wire logic [1:0] CLOCK_SOURCE_SELECT, // Select.
    input wire logic OSCILLATOR_BYPASS, // Bypass.
    input wire logic PRESCALE_DIVIDER_FIELD_IN_SEL, // Input.
    input wire logic [9:0] PRESCALE_DIVIDER_FIELD, // Field.
    input wire logic EXT_CLOCK_PIN, // Pin.
    input wire logic CRYSTAL_INPUT_PIN, // Crystal.
    input wire logic INT_CLOCK, // Internal.
    input wire logic WAKEUP_CLOCK, // Wakeup.
    input wire logic LOOP_CLOCK, // Loop.
    input wire logic SYS_CLOCK, // Output.
    input wire logic SWITCH_BUSY, // Busy.
    input wire logic [3:0] ACTIVE_MODE // Mode.
);
    // ----------------------------------------------------------------
    // Settled history
    // ----------------------------------------------------------------
    // A path is judged only after busy was low for two cycles.
    logic [1:0] run_q;
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            run_q <= 2'h0;
        end else begin
            run_q <= {run_q[0], !SWITCH_BUSY};
        end
    end
    wire logic ok = !SWITCH_BUSY && run_q == 2'h3;
    wire logic pre = ACTIVE_MODE[3:1] == 3'b101 && ok;
    wire logic [9:0] fld = PRESCALE_DIVIDER_FIELD;
    // A zero field is taken only at a wrap, seen as an output change while
    // the field stood at zero; until then the old factor may still divide.
    logic zero_q;
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            zero_q <= 1'b1;
        end else if (fld != 10'h000) begin
            zero_q <= 1'b0;
        end else if (pre && $changed(SYS_CLOCK) && $past(fld) == 10'h000
                     && $past(fld, 2) == 10'h000) begin
            zero_q <= 1'b1;
        end
    end
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);
    AST_WAKE: assert property (!ACTIVE_MODE[3] && ok
        |-> SYS_CLOCK == $past(WAKEUP_CLOCK)) else $error("wakeup path");
    AST_DIRECT: assert property (ACTIVE_MODE[3:2] == 2'h3 && ok
        |-> SYS_CLOCK == $past(EXT_CLOCK_PIN)) else $error("pin path");
    AST_LOOP: assert property (ACTIVE_MODE[3:1] == 3'b100 && ok
        |-> SYS_CLOCK == $past(LOOP_CLOCK)) else $error("loop path");
    AST_ONE: assert property (pre && fld == 10'h000 && zero_q
        && $past(fld, 2) == 10'h000 |-> SYS_CLOCK ==
        $past(ACTIVE_MODE[0] ? INT_CLOCK : CRYSTAL_INPUT_PIN, 2))
        else $error("factor one path");
    AST_SLOW: assert property (pre && fld != 10'h000
        && $past(fld, 2) != 10'h000 && $changed(SYS_CLOCK)
        |=> $stable(SYS_CLOCK)) else $error("divided too fast");
    AST_TAKE: assert property (!SWITCH_BUSY && ACTIVE_MODE !=
        {CLOCK_SOURCE_SELECT, OSCILLATOR_BYPASS,
        PRESCALE_DIVIDER_FIELD_IN_SEL} |=> SWITCH_BUSY)
        else $error("switch not taken");
    AST_PARK: assert property ($changed(ACTIVE_MODE)
        |-> !SYS_CLOCK ##1 !SYS_CLOCK) else $error("runt at switch");
    AST_HOLD: assert property ($rose(SWITCH_BUSY)
        |-> $stable(ACTIVE_MODE)) else $error("mode loaded early");
    cover property (ACTIVE_MODE == 4'hc && ok);
    cover property (pre && fld == 10'h3ff);
    cover property ($fell(SWITCH_BUSY));
endmodule : sccs_sva

bind sccs_top sccs_sva sva_u (.MCLK, .RESET_N, .CLOCK_SOURCE_SELECT,
    .OSCILLATOR_BYPASS, .PRESCALE_DIVIDER_FIELD_IN_SEL,
    .PRESCALE_DIVIDER_FIELD, .EXT_CLOCK_PIN, .CRYSTAL_INPUT_PIN,
    .INT_CLOCK, .WAKEUP_CLOCK, .LOOP_CLOCK, .SYS_CLOCK, .SWITCH_BUSY,
    .ACTIVE_MODE);

// ### sccs_src_model.sv
/* Model of the five clock sources, free running.
   Assumes it is clocked by the bench clock. */
`timescale 1ns/1ns
module sccs_src_model (
    input wire logic mclk, // Bench clock.
    output logic [4:0] lvl // Wakeup, loop, internal, crystal, pin.
);
    // ----------------------------------------------------------------
    // Sources
    // ----------------------------------------------------------------
    // Half periods differ so that a wrong pick shows at once.
    int cnt = 0;
    always @(negedge mclk) begin
        cnt <= cnt + 1;
        lvl <= {cnt / 9 % 2 == 1, cnt / 2 % 2 == 1, cnt / 5 % 2 == 1,
            cnt / 4 % 2 == 1, cnt / 3 % 2 == 1};
    end
endmodule : sccs_src_model

// ### test_system_clock_source_select.sv
/* Bench for sccs_top: mode table, random modes, divided runs.
   Assumes sccs_src_model drives the sources. */
`timescale 1ns/1ns
module test_system_clock_source_select;
    logic MCLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [3:0] mw = 4'h0;
    logic [9:0] fld = 10'h000;
    logic [4:0] lvl, h1, h2;
    logic sys, busy;
    logic [3:0] am;
    logic [3:0] tbl [6] = '{4'h0, 4'h4, 4'hc, 4'h8, 4'ha, 4'hb};
    int bad_count = 0;
    int check_count = 0;
    int seed = 32'h2d64b284;
    int n;
    sccs_src_model src_u (.mclk(MCLK), .lvl(lvl));
    sccs_top dut_u (.MCLK(MCLK), .RESET_N(RESET_N),
        .CLOCK_SOURCE_SELECT(mw[3:2]), .OSCILLATOR_BYPASS(mw[1]),
        .PRESCALE_DIVIDER_FIELD_IN_SEL(mw[0]),
        .PRESCALE_DIVIDER_FIELD(fld), .EXT_CLOCK_PIN(lvl[0]),
        .CRYSTAL_INPUT_PIN(lvl[1]), .INT_CLOCK(lvl[2]),
        .LOOP_CLOCK(lvl[3]), .WAKEUP_CLOCK(lvl[4]),
        .SYS_CLOCK(sys), .SWITCH_BUSY(busy), .ACTIVE_MODE(am));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    initial begin
        forever #4 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        h1 <= lvl;
        h2 <= h1;
    end
    function automatic logic pick(input logic [3:0] m);
        logic [4:0] l;
        l = (m[3:1] == 3'b101) ? h2 : h1;
        if (m[3:2] == 2'h3) return l[0];
        if (!m[3]) return l[4];
        if (!m[1]) return l[3];
        return m[0] ? l[2] : l[1];
    endfunction : pick
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic waitv(input logic [3:0] m, input logic v, input bit s);
        int i;
        for (i = 0; i < 9000; i++) begin
            if (s ? sys === v : am === m && busy === 1'b0) break;
            @(negedge MCLK);
        end
        chk(i < 9000, "wait ran out");
        if (i == 9000) tally_and_finish();
    endtask : waitv
    task automatic follow(input logic [3:0] m);
        mw = m;
        waitv(m, 1'b0, 1'b0);
        repeat (3) @(negedge MCLK);
        repeat (40) begin
            @(negedge MCLK);
            chk(sys === pick(m), "wrong clock");
        end
        $display("mode %h done", m);
    endtask : follow
    task automatic runlen(input logic [9:0] f);
        int k;
        fld = f;
        // The first rise may come from the factor-one path; time the second.
        waitv(mw, 1'b0, 1'b1);
        waitv(mw, 1'b1, 1'b1);
        waitv(mw, 1'b0, 1'b1);
        waitv(mw, 1'b1, 1'b1);
        for (k = 0; k < 9000 && sys === 1'b1; k++) begin
            @(negedge MCLK);
        end
        chk(k == (int'(f) + 1) * (mw[0] ? 5 : 4), "high time");
        $display("divide %0d done", f);
    endtask : runlen
    initial begin
        repeat (20) @(negedge MCLK);
        RESET_N = 1'b1;
        foreach (tbl[j]) begin
            follow(tbl[j]);
        end
        for (n = 0; n < 6; n++) begin
            follow(4'($random(seed)));
        end
        follow(4'ha);
        for (n = 0; n < 3; n++) begin
            runlen(10'(($random(seed) & 3) + 1));
        end
        // Factor one is taken at the next wrap, so let one pass first.
        fld = 10'h000;
        waitv(mw, 1'b0, 1'b1);
        waitv(mw, 1'b1, 1'b1);
        follow(4'hb);
        runlen(10'h3ff);
        tally_and_finish();
    end
endmodule : test_system_clock_source_select
